// File: core/elb_top.sv
// ethernet loopback control and per-frame status block
// assumes a classic wishbone master, frame events from tx/rx engines on i_clk,
// and pins from the transceiver that are asynchronous to i_clk
//
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
module elb_top
  import elb_pkg::*;
(
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  // wishbone slave
  input  wire logic                        i_wb_cyc,
  input  wire logic                        i_wb_stb,
  input  wire logic                        i_wb_we,
  input  wire logic [elb_pkg::ADDR_W-1:0]  i_wb_adr,
  input  wire logic [3:0]                  i_wb_sel,
  input  wire logic [31:0]                 i_wb_dat,
  output logic      [31:0]                 o_wb_dat,
  output logic                             o_wb_ack,
  // mac-side serial path
  input  wire logic                        i_mac_tx_bit,
  input  wire logic                        i_mac_tx_en,
  output logic                             o_mac_rx_bit,
  output logic                             o_mac_rx_dv,
  // wire side (transceiver), asynchronous
  output logic                             o_line_tx_bit,
  output logic                             o_line_tx_en,
  input  wire logic                        i_line_rx_bit,
  input  wire logic                        i_line_rx_dv,
  // filter controls for the rx engine
  output logic                             o_src_check_en,
  output logic                             o_filter_en,
  // tx frame completion
  input  wire logic                        i_tx_done,
  input  wire logic                        i_tx_deferred,
  input  wire logic [3:0]                  i_tx_coll_cnt,
  input  wire logic                        i_tx_no_carrier,
  input  wire logic                        i_tx_excess_coll,
  input  wire logic [9:0]                  i_tx_tdr,
  input  wire logic                        i_tx_late_coll,
  input  wire logic                        i_tx_heartbeat_fail,
  input  wire logic [15:0]                 i_tx_buf_size,
  // rx frame completion
  input  wire logic                        i_rx_done,
  input  wire logic                        i_rx_crc_err,
  input  wire logic                        i_rx_dribble,
  input  wire logic                        i_rx_overrun,
  input  wire logic [13:0]                 i_rx_len,
  input  wire logic                        i_rx_no_buffer,
  input  wire logic                        i_rx_in_frame,
  input  wire logic                        i_tx_in_frame,
  input  wire logic                        i_init_fail,
  output logic                             o_tx_run,
  output logic                             o_rx_run,
  output logic                             o_tx_irq_evt,
  output logic                             o_rx_irq_evt
);
  import elb_pkg::*;

  logic        rst_s1_r;
  logic        rst_n_r;
  logic [1:0]  om_r;
  logic        tx_start_r;
  logic        rx_start_r;
  logic        promisc_r;
  logic [31:0] rx_base_r;
  logic [31:0] tx_base_r;
  logic [15:0] missed_r;
  logic        init_fail_r;
  logic [31:0] tx_status_r;
  logic [31:0] rx_status_r;
  logic [31:0] tx_buffer_r;
  logic        tx_irq_r;
  logic        rx_irq_r;
  elb_ps_e     tx_state_r;
  elb_ps_e     rx_state_r;
  logic        line_rx_bit_s1_r;
  logic        line_rx_bit_s2_r;
  logic        line_rx_dv_s1_r;
  logic        line_rx_dv_s2_r;
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] wmask;
  logic [31:0] mode_word;
  logic [31:0] stat_word;

  // reset release through two flops
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // wishbone: one answer per strobe, registered one cycle after it, ack dropped the cycle after
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_wr  = wb_req && i_wb_we;
  assign wmask  = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

  assign mode_word = {27'h0, promisc_r, rx_start_r, tx_start_r, om_r};
  assign stat_word = {25'h0, rx_irq_r, tx_irq_r, init_fail_r, rx_state_r, tx_state_r};

  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= RST_WORD;
    end
    else
    begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we)
      begin
        unique case (i_wb_adr)
          OFF_STATUS_CSR:   o_wb_dat <= stat_word;
          OFF_MODE_CSR:     o_wb_dat <= mode_word;
          OFF_RX_LIST_BASE: o_wb_dat <= rx_base_r;
          OFF_TX_LIST_BASE: o_wb_dat <= tx_base_r;
          OFF_MISSED_CSR:   o_wb_dat <= {16'h0, missed_r};
          OFF_TX_STATUS:    o_wb_dat <= tx_status_r;
          OFF_RX_STATUS:    o_wb_dat <= rx_status_r;
          OFF_TX_BUFFER:    o_wb_dat <= tx_buffer_r;
          default:          o_wb_dat <= RST_WORD;
        endcase
      end
    end
  end

  // mode and list base registers
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      om_r       <= ELB_OM_NORMAL;
      tx_start_r <= 1'b0;
      rx_start_r <= 1'b0;
      promisc_r  <= 1'b0;
      rx_base_r  <= RST_WORD;
      tx_base_r  <= RST_WORD;
    end
    else if (wb_wr)
    begin
      if (i_wb_adr == OFF_MODE_CSR && i_wb_sel[0])
      begin
        // mode only changes while both processes are stopped
        if (tx_state_r == ELB_PS_STOPPED && rx_state_r == ELB_PS_STOPPED)
          om_r <= i_wb_dat[MODE_OM_LSB +: 2];
        tx_start_r <= i_wb_dat[MODE_ST_BIT];
        rx_start_r <= i_wb_dat[MODE_SR_BIT];
        promisc_r  <= i_wb_dat[MODE_PR_BIT];
      end
      if (i_wb_adr == OFF_RX_LIST_BASE)
        rx_base_r <= (rx_base_r & ~wmask) | (i_wb_dat & wmask);
      if (i_wb_adr == OFF_TX_LIST_BASE)
        tx_base_r <= (tx_base_r & ~wmask) | (i_wb_dat & wmask);
    end
  end

  // process states: stop waits for the current frame to end
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tx_state_r <= ELB_PS_STOPPED;
      rx_state_r <= ELB_PS_STOPPED;
    end
    else
    begin
      if (tx_start_r)
        tx_state_r <= ELB_PS_RUNNING;
      else if (!i_tx_in_frame)
        tx_state_r <= ELB_PS_STOPPED;
      if (rx_start_r)
        rx_state_r <= ELB_PS_RUNNING;
      else if (!i_rx_in_frame)
        rx_state_r <= ELB_PS_STOPPED;
    end
  end

  assign o_tx_run = (tx_state_r == ELB_PS_RUNNING);
  assign o_rx_run = (rx_state_r == ELB_PS_RUNNING);

  // line inputs synchronised before use
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      line_rx_bit_s1_r <= 1'b0;
      line_rx_bit_s2_r <= 1'b0;
      line_rx_dv_s1_r  <= 1'b0;
      line_rx_dv_s2_r  <= 1'b0;
    end
    else
    begin
      line_rx_bit_s1_r <= i_line_rx_bit;
      line_rx_bit_s2_r <= line_rx_bit_s1_r;
      line_rx_dv_s1_r  <= i_line_rx_dv;
      line_rx_dv_s2_r  <= line_rx_dv_s1_r;
    end
  end

  // loopback routing, registered outputs
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      o_line_tx_bit <= 1'b0;
      o_line_tx_en  <= 1'b0;
      o_mac_rx_bit  <= 1'b0;
      o_mac_rx_dv   <= 1'b0;
    end
    else if (om_r == ELB_OM_INT_LOOP)
    begin
      // wire side held idle; receive path fed from transmit
      o_line_tx_bit <= 1'b0;
      o_line_tx_en  <= 1'b0;
      o_mac_rx_bit  <= i_mac_tx_bit;
      o_mac_rx_dv   <= i_mac_tx_en;
    end
    else
    begin
      // normal and external: line carries our frames and is heard back
      o_line_tx_bit <= i_mac_tx_bit;
      o_line_tx_en  <= i_mac_tx_en;
      o_mac_rx_bit  <= line_rx_bit_s2_r;
      o_mac_rx_dv   <= line_rx_dv_s2_r;
    end
  end

  // no origin filter exists in any mode; destination filter on unless promiscuous
  assign o_src_check_en = 1'b0;
  assign o_filter_en    = !promisc_r;

  // tx status word capture
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tx_status_r <= RST_WORD;
      tx_buffer_r <= RST_WORD;
    end
    else if (i_tx_done)
    begin
      tx_status_r <= RST_WORD;
      tx_status_r[TXS_DE_BIT]       <= i_tx_deferred;
      tx_status_r[TXS_CC_LSB +: 4]  <= i_tx_coll_cnt;
      tx_status_r[TXS_NC_BIT]       <= i_tx_no_carrier;
      tx_status_r[TXS_EC_BIT]       <= i_tx_excess_coll;
      tx_status_r[TXS_TDR_LSB +: 10] <= i_tx_excess_coll ? i_tx_tdr : 10'h0;
      tx_status_r[TXS_LC_BIT]       <= i_tx_late_coll;
      tx_status_r[TXS_HF_BIT]       <= i_tx_heartbeat_fail;
      tx_buffer_r <= {16'h0, i_tx_buf_size};
    end
  end

  // rx status word capture
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rx_status_r <= RST_WORD;
    else if (i_rx_done)
    begin
      rx_status_r <= RST_WORD;
      rx_status_r[RXS_CE_BIT]      <= i_rx_crc_err;
      rx_status_r[RXS_DB_BIT]      <= i_rx_dribble;
      rx_status_r[RXS_TL_BIT]      <= (i_rx_len > MAX_FRAME_LEN);
      rx_status_r[RXS_OF_BIT]      <= i_rx_overrun;
      rx_status_r[RXS_FL_LSB +: 14] <= i_rx_len;
    end
  end

  // missed frames: saturating, read-only counter
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      missed_r <= 16'h0;
    else if (i_rx_no_buffer && missed_r != 16'hffff)
      missed_r <= missed_r + 16'h1;
  end

  // sticky status bits; tx/rx irq bits clear on a written one, a new event wins over clear; init fail clears only on reset
  always_ff @(posedge i_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      init_fail_r <= 1'b0;
      tx_irq_r    <= 1'b0;
      rx_irq_r    <= 1'b0;
    end
    else
    begin
      if (i_init_fail)
        init_fail_r <= 1'b1;
      if (i_tx_done)
        tx_irq_r <= 1'b1;
      else if (wb_wr && i_wb_adr == OFF_STATUS_CSR && i_wb_dat[STAT_TI_BIT])
        tx_irq_r <= 1'b0;
      if (i_rx_done)
        rx_irq_r <= 1'b1;
      else if (wb_wr && i_wb_adr == OFF_STATUS_CSR && i_wb_dat[STAT_RI_BIT])
        rx_irq_r <= 1'b0;
    end
  end

  // completion pulses reach the outside in every mode
  assign o_tx_irq_evt = i_tx_done;
  assign o_rx_irq_evt = i_rx_done;

  AST_INT_LOOP_QUIET: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    (om_r == ELB_OM_INT_LOOP) |=> !o_line_tx_en)
    else $error("line driven in internal loopback");
  AST_INT_LOOP_ROUTE: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    (om_r == ELB_OM_INT_LOOP) |=> (o_mac_rx_dv == $past(i_mac_tx_en)))
    else $error("internal loop not routed");
  AST_EXT_LOOP_TX: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    (om_r == ELB_OM_EXT_LOOP) |=> (o_line_tx_en == $past(i_mac_tx_en)))
    else $error("external loop not transmitting");
  AST_NO_SRC_CHECK: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    !o_src_check_en)
    else $error("source check enabled");
  AST_FILTER_ON: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    !promisc_r |-> o_filter_en)
    else $error("filter off");
  AST_TX_DEFER: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_tx_done |=> (tx_status_r[TXS_DE_BIT] == $past(i_tx_deferred)))
    else $error("deferred flag wrong");
  AST_TX_CC: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_tx_done |=> (tx_status_r[TXS_CC_LSB +: 4] == $past(i_tx_coll_cnt)))
    else $error("collision count wrong");
  AST_RX_TL: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    (i_rx_done && i_rx_len > MAX_FRAME_LEN) |=> rx_status_r[RXS_TL_BIT])
    else $error("too long flag missing");
  AST_MISSED: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    (i_rx_no_buffer && missed_r != 16'hffff) |=> (missed_r == $past(missed_r) + 16'h1))
    else $error("missed counter stuck");
  AST_INIT_FAIL: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    i_init_fail |=> stat_word[STAT_SF_BIT])
    else $error("init fail not flagged");
  AST_RX_STOP: assert property (@(posedge i_clk) disable iff (!rst_n_r)
    (!rx_start_r && i_rx_in_frame && o_rx_run) |=> o_rx_run)
    else $error("rx stopped mid frame");
endmodule // elb_top

// File: core/elb_pkg.sv
// package for the ethernet loopback/status block
// assumes a 32-bit classic wishbone register bus and one 100 MHz clock
package elb_pkg;
  localparam int unsigned ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_STATUS_CSR   = 8'h00;
  localparam logic [7:0] OFF_MODE_CSR     = 8'h04;
  localparam logic [7:0] OFF_RX_LIST_BASE = 8'h08;
  localparam logic [7:0] OFF_TX_LIST_BASE = 8'h0c;
  localparam logic [7:0] OFF_MISSED_CSR   = 8'h10;
  localparam logic [7:0] OFF_TX_STATUS    = 8'h14;
  localparam logic [7:0] OFF_RX_STATUS    = 8'h18;
  localparam logic [7:0] OFF_TX_BUFFER    = 8'h1c;
  // operating_mode_field codes
  typedef enum logic [1:0] {
    ELB_OM_NORMAL   = 2'h0,
    ELB_OM_INT_LOOP = 2'h1,
    ELB_OM_EXT_LOOP = 2'h2
  } elb_om_e;
  // process state codes shown in status_csr
  typedef enum logic [1:0] {
    ELB_PS_STOPPED   = 2'h0,
    ELB_PS_RUNNING   = 2'h1,
    ELB_PS_SUSPENDED = 2'h2
  } elb_ps_e;
  // mode_csr fields
  localparam int unsigned MODE_OM_LSB  = 0;
  localparam int unsigned MODE_ST_BIT  = 2;  // start/stop tx
  localparam int unsigned MODE_SR_BIT  = 3;  // start/stop rx
  localparam int unsigned MODE_PR_BIT  = 4;  // promiscuous
  // status_csr fields
  localparam int unsigned STAT_TS_LSB  = 0;
  localparam int unsigned STAT_RS_LSB  = 2;
  localparam int unsigned STAT_SF_BIT  = 4;
  localparam int unsigned STAT_TI_BIT  = 5;
  localparam int unsigned STAT_RI_BIT  = 6;
  // tx_status_word fields
  localparam int unsigned TXS_DE_BIT   = 0;
  localparam int unsigned TXS_CC_LSB   = 1;  // 4 bits
  localparam int unsigned TXS_NC_BIT   = 5;
  localparam int unsigned TXS_EC_BIT   = 6;
  localparam int unsigned TXS_LC_BIT   = 7;
  localparam int unsigned TXS_HF_BIT   = 8;
  localparam int unsigned TXS_TDR_LSB  = 16; // 10 bits
  // rx_status_word fields
  localparam int unsigned RXS_CE_BIT   = 0;
  localparam int unsigned RXS_DB_BIT   = 1;
  localparam int unsigned RXS_TL_BIT   = 2;
  localparam int unsigned RXS_OF_BIT   = 3;
  localparam int unsigned RXS_FL_LSB   = 16; // 14 bits
  localparam logic [13:0] MAX_FRAME_LEN = 14'd1518;
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
endpackage

// File: test/elb_line_model.sv
// transceiver and cable stand-in for the wire side of elb_top
// assumes bench-driven foreign traffic on i_fgn_*; cable echoes with no delay
`timescale 1ns/10ps
module elb_line_model
(
  input  wire logic i_clk,
  input  wire logic i_tx_bit,
  input  wire logic i_tx_en,
  input  wire logic i_fgn_bit,
  input  wire logic i_fgn_en,
  output logic      o_rx_bit,
  output logic      o_rx_dv
);
  logic idle_r = 1'b0;
  // an idle line toggles so a stale bit can never pass for data;
  // seeded so the toggle starts from a known level, not unknown
  always @(posedge i_clk)
  begin
    idle_r <= ~o_rx_bit;
  end
  // own transmission is heard back on the same line
  // other stations may talk while we are silent
  assign o_rx_dv  = i_tx_en | i_fgn_en;
  assign o_rx_bit = i_tx_en ? i_tx_bit : (i_fgn_en ? i_fgn_bit : idle_r);
endmodule // elb_line_model

// File: test/elb_top_tb.sv
// self-checking bench for elb_top: wishbone register tasks, loop paths,
// frame status events; a monitor compares read data against queued notes
`timescale 1ns/10ps
module elb_top_tb;
  import elb_pkg::*;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, seed = 32'hf36a43b1, exp, exp_m;
  logic [3:0]  sel = 4'hf;
  logic        mtx_bit = 0, mtx_en = 0, fgn_bit = 0, fgn_en = 0;
  logic        tx_done = 0, de = 0, nc = 0, ec = 0, lc = 0, hf = 0;
  logic        rx_done = 0, ce = 0, db = 0, ov = 0, nobuf = 0;
  logic        rx_inf = 0, tx_inf = 0, ifail = 0;
  logic [3:0]  cc = 4'h0;
  logic [9:0]  tdr = 10'h0;
  logic [15:0] bsz = 16'h0;
  logic [13:0] len = 14'h0;
  logic [7:0]  hist = 8'h0;
  logic        b;
  logic [31:0] wb_do, mac_rx_bit, mac_rx_dv, ltx_bit, ltx_en, lrx_bit, lrx_dv;
  logic        ack, src_chk, filt, tx_irq, rx_irq, tx_run, rx_run;
  logic [31:0] exp_q[$], msk_q[$];
  int          errors = 0, total_checks = 0;
  always #5 clk = ~clk;
  elb_top elb_top_i (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(wb_do),
    .o_wb_ack(ack), .i_mac_tx_bit(mtx_bit), .i_mac_tx_en(mtx_en),
    .o_mac_rx_bit(mac_rx_bit[0]), .o_mac_rx_dv(mac_rx_dv[0]), .o_line_tx_bit(ltx_bit[0]),
    .o_line_tx_en(ltx_en[0]), .i_line_rx_bit(lrx_bit[0]), .i_line_rx_dv(lrx_dv[0]),
    .o_src_check_en(src_chk), .o_filter_en(filt), .i_tx_done(tx_done),
    .i_tx_deferred(de), .i_tx_coll_cnt(cc), .i_tx_no_carrier(nc), .i_tx_excess_coll(ec),
    .i_tx_tdr(tdr), .i_tx_late_coll(lc), .i_tx_heartbeat_fail(hf), .i_tx_buf_size(bsz),
    .i_rx_done(rx_done), .i_rx_crc_err(ce), .i_rx_dribble(db), .i_rx_overrun(ov),
    .i_rx_len(len), .i_rx_no_buffer(nobuf), .i_rx_in_frame(rx_inf),
    .i_tx_in_frame(tx_inf), .i_init_fail(ifail), .o_tx_run(tx_run), .o_rx_run(rx_run),
    .o_tx_irq_evt(tx_irq), .o_rx_irq_evt(rx_irq));
  elb_line_model elb_line_model_i (.i_clk(clk), .i_tx_bit(ltx_bit[0]), .i_tx_en(ltx_en[0]),
    .i_fgn_bit(fgn_bit), .i_fgn_en(fgn_en), .o_rx_bit(lrx_bit[0]), .o_rx_dv(lrx_dv[0]));
  assign {mac_rx_bit[31:1], mac_rx_dv[31:1], ltx_bit[31:1]} = '0;
  assign {ltx_en[31:1], lrx_bit[31:1], lrx_dv[31:1]} = '0;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // read results are judged here, oldest note first
  always @(posedge clk)
  begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
    begin
      exp_m = msk_q.pop_front();
      chk(wb_do & exp_m, exp_q.pop_front() & exp_m);
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
    end
    if (n == 20)
    begin
      errors++;
      test_done();
    end
    rdat = wb_do;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    wb(0, a, 32'h0);
  endtask
  // stopped means both state fields read zero; polling is bounded
  task automatic wait_stopped();
    for (int n = 0; n < 20; n++)
    begin
      rd(OFF_STATUS_CSR, 32'h0, 32'h0);
      if (rdat[3:0] === 4'h0)
        break;
    end
    if (rdat[3:0] !== 4'h0)
    begin
      errors++;
      test_done();
    end
  endtask
  // lat is edges from drive to sample; a history shift keeps what was sent
  task automatic run_bits(input int lat, input logic fgn);
    for (int j = 0; j < 40; j++)
    begin
      @(posedge clk);
      if (j > 8)
      begin
        chk(mac_rx_bit, hist[lat]);
        chk(mac_rx_dv, 32'h1);
        if (lat == 1)
          chk(ltx_en, 32'h0);
        if (lat == 4)
          chk(ltx_bit, hist[1]);
      end
      b = seed[0];
      seed = lfsr(seed);
      mtx_bit <= b; fgn_bit <= b; mtx_en <= ~fgn; fgn_en <= fgn;
      hist = {hist[6:0], b};
    end
    @(posedge clk);
    mtx_en <= 0; fgn_en <= 0;
    repeat (6) @(posedge clk);
  endtask
  initial
  begin
    #1000000;
    errors++;
    test_done();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rd(OFF_STATUS_CSR, 32'h0, 32'h7f);
    rd(OFF_MODE_CSR, 32'h0, 32'h1f);
    rd(OFF_MISSED_CSR, 32'h0, 32'hffff);
    chk(src_chk, 32'h0);
    chk(filt, 32'h1);
    exp = seed;
    seed = lfsr(seed);
    wb(1, OFF_RX_LIST_BASE, exp);
    wb(1, OFF_TX_LIST_BASE, ~exp);
    rd(OFF_RX_LIST_BASE, exp, 32'hffffffff);
    rd(OFF_TX_LIST_BASE, ~exp, 32'hffffffff);
    sel <= 4'h3;
    wb(1, OFF_TX_LIST_BASE, exp);
    sel <= 4'hf;
    rd(OFF_TX_LIST_BASE, {~exp[31:16], exp[15:0]}, 32'hffffffff);
    wb(1, 8'h20, exp);
    rd(8'h20, 32'h0, 32'hffffffff);
    wb(1, OFF_MODE_CSR, 32'h1);
    wb(1, OFF_MODE_CSR, 32'hd);
    rd(OFF_MODE_CSR, 32'hd, 32'h1f);
    run_bits(1, 0);
    wb(1, OFF_MODE_CSR, 32'he);
    rd(OFF_MODE_CSR, 32'h1, 32'h3);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clk);
      de <= (i == 0); cc <= (i == 0) ? 4'h1 : (i == 1) ? 4'h5 : 4'h0;
      lc <= (i == 1); nc <= (i == 2); hf <= (i == 2); ec <= (i == 3);
      tdr <= seed[9:0]; bsz <= seed[31:16]; tx_done <= 1;
      exp = 32'h0;
      exp[TXS_DE_BIT] = (i == 0);
      exp[TXS_CC_LSB+:4] = (i == 0) ? 4'h1 : (i == 1) ? 4'h5 : 4'h0;
      exp[TXS_LC_BIT] = (i == 1);
      exp[TXS_NC_BIT] = (i == 2);
      exp[TXS_HF_BIT] = (i == 2);
      exp[TXS_EC_BIT] = (i == 3);
      exp[TXS_TDR_LSB+:10] = (i == 3) ? seed[9:0] : 10'h0;
      @(posedge clk);
      chk(tx_irq, 32'h1);
      tx_done <= 0;
      rd(OFF_TX_STATUS, exp, 32'h3ff01ff);
      rd(OFF_TX_BUFFER, {16'h0, seed[31:16]}, 32'hffff);
      seed = lfsr(seed);
    end
    rx_inf <= 1;
    wb(1, OFF_MODE_CSR, 32'h1);
    rd(OFF_STATUS_CSR, 32'h4, 32'hf);
    chk(rx_run, 32'h1);
    chk(tx_run, 32'h0);
    rx_inf <= 0;
    wait_stopped();
    rd(OFF_STATUS_CSR, 32'h0, 32'hf);
    wb(1, OFF_MODE_CSR, 32'h2);
    wb(1, OFF_MODE_CSR, 32'he);
    rd(OFF_MODE_CSR, 32'he, 32'h1f);
    run_bits(4, 0);
    run_bits(3, 1);
    chk(src_chk, 32'h0);
    chk(filt, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      ce <= i[0]; db <= i[1]; ov <= (i == 2);
      len <= (i == 3) ? 14'd1519 : 14'd1518; rx_done <= 1;
      @(posedge clk);
      chk(rx_irq, 32'h1);
      rx_done <= 0;
      exp = {2'h0, (i == 3) ? 14'd1519 : 14'd1518, 12'h0, i == 2, i == 3, i[1], i[0]};
      rd(OFF_RX_STATUS, exp, 32'h3fff000f);
    end
    repeat (3)
    begin
      @(posedge clk);
      nobuf <= 1;
      @(posedge clk);
      nobuf <= 0;
    end
    rd(OFF_MISSED_CSR, 32'h3, 32'hffff);
    @(posedge clk);
    ifail <= 1;
    @(posedge clk);
    ifail <= 0;
    rd(OFF_STATUS_CSR, 32'h70, 32'h70);
    wb(1, OFF_STATUS_CSR, 32'h60);
    rd(OFF_STATUS_CSR, 32'h10, 32'h70);
    wb(1, OFF_MODE_CSR, 32'h2);
    wait_stopped();
    wb(1, OFF_MODE_CSR, 32'h10);
    chk(filt, 32'h0);
    wb(1, OFF_MODE_CSR, 32'h0);
    rd(OFF_MODE_CSR, 32'h0, 32'h1f);
    chk(filt, 32'h1);
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule // elb_top_tb
